// [shared/transceiver_tx_control_diag_pkg.sv]
package transceiver_tx_control_diag_pkg;

    // two-wire device addresses, eight-bit form with the r/w bit at zero
    localparam logic [7:0] DEV_ADDR_ID = 8'ha0;
    localparam logic [7:0] DEV_ADDR_DIAG = 8'ha2;

    // memory geometry
    localparam int MEM_BYTES = 256;
    localparam int PTR_W = 8;

    // diagnostic memory offsets
    localparam logic [7:0] OFS_TX_RX_CONTROL_STATUS = 8'h6e;
    localparam logic [7:0] OFS_TEMP = 8'h60;
    localparam logic [7:0] OFS_VCC = 8'h62;
    localparam logic [7:0] OFS_TX_BIAS = 8'h64;
    localparam logic [7:0] OFS_TX_POWER = 8'h66;
    localparam logic [7:0] OFS_RX_POWER = 8'h68;

    // fields of tx_rx_control_status
    localparam int BIT_DISABLE_STATE = 7;
    localparam int BIT_SOFT_DISABLE = 6;
    localparam int BIT_TX_FAULT = 2;
    localparam int BIT_RX_SIGNAL_LOST = 1;

    // reset values and bits per byte
    localparam logic RST_SOFT_DISABLE = 1'b0;
    localparam logic RST_HW_DISABLE_SEEN = 1'b1;
    localparam logic [7:0] RST_PTR = 8'h00;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    // two-wire slave states
    typedef enum logic [8:0] {
        TW_IDLE = 9'h001,
        TW_ADDR = 9'h002,
        TW_ADDR_ACK = 9'h004,
        TW_WADDR = 9'h008,
        TW_WADDR_ACK = 9'h010,
        TW_WDATA = 9'h020,
        TW_WDATA_ACK = 9'h040,
        TW_RDATA = 9'h080,
        TW_RDATA_ACK = 9'h100
    } tw_state_t;

endpackage

// [design/tx_laser_guard.sv]
`timescale 1ns/10ps
module tx_laser_guard
    import transceiver_tx_control_diag_pkg::*;
(
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    // control
    input wire logic hw_disable_i,
    input wire logic soft_disable_i,
    input wire logic fault_event_i,
    // state
    output logic laser_on_o,
    output logic fault_o
);

    typedef struct packed {
        logic hw_seen;
        logic fault;
        logic laser_on;
    } guard_state_t;

    guard_state_t s_q;
    guard_state_t s_d;
    logic disable_rise;

    assign disable_rise = hw_disable_i & ~s_q.hw_seen;

    always_comb
    begin
        s_d = s_q;
        s_d.hw_seen = hw_disable_i;
        // a fault in the very cycle of the clearing edge survives
        s_d.fault = fault_event_i | (s_q.fault & ~disable_rise);
        s_d.laser_on = ~hw_disable_i & ~soft_disable_i & ~s_d.fault;
    end

    // pin assumed high at power-on, so release of reset is no clearing edge
    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            s_q <= '{hw_seen: RST_HW_DISABLE_SEEN, fault: 1'b0, laser_on: 1'b0};
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign laser_on_o = s_q.laser_on;
    assign fault_o = s_q.fault;

endmodule

// [design/transceiver_tx_control_diag.sv]
`timescale 1ns/10ps
module transceiver_tx_control_diag
    import transceiver_tx_control_diag_pkg::*;
#(
    parameter int MON_W = 16
)
(
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    // transmit disable pin, with driven flag standing in for the pull-up
    input wire logic tx_disable_pin_i,
    input wire logic tx_disable_driven_i,
    // fault sources
    input wire logic laser_fault_i,
    input wire logic unsafe_power_i,
    // receiver status
    input wire logic rx_signal_lost_i,
    // live monitor values
    input wire logic [MON_W-1:0] temp_i,
    input wire logic [MON_W-1:0] vcc_i,
    input wire logic [MON_W-1:0] tx_bias_i,
    input wire logic [MON_W-1:0] tx_power_i,
    input wire logic [MON_W-1:0] rx_power_i,
    // two-wire serial
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    // status pins and laser control
    output logic laser_enable_o,
    output logic tx_fault_o,
    output logic tx_fault_oe_o,
    output logic rx_signal_lost_pin_o
);

    if (MON_W != 16)
    begin : g_check_mon
        $error("monitor values must be 16 bits, two bytes each");
    end
    if (MEM_BYTES != (1 << PTR_W))
    begin : g_check_mem
        $error("memory size must match pointer width");
    end

    ////////////////////////////////////////////////////////////////////////////////

    typedef struct packed {
        tw_state_t st;
        logic scl_q;
        logic sda_q;
        logic [3:0] bit_cnt;
        logic [7:0] shreg;
        logic sel_diag;
        logic rd_mode;
        logic rd_more;
        logic [PTR_W-1:0] ptr;
        logic sda_oe;
        logic soft_disable;
        logic hw_disable;
        logic rx_lost;
        logic fault_oe;
        logic laser_en;
    } slave_state_t;

    slave_state_t s_q;
    slave_state_t s_d;

    logic [7:0] id_mem [MEM_BYTES];
    logic [7:0] diag_mem [MEM_BYTES];

    logic hw_disable_w;
    logic laser_on_w;
    logic fault_w;
    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;
    logic mem_we;
    logic [7:0] status_byte;
    logic [7:0] rd_byte;

    ////////////////////////////////////////////////////////////////////////////////

    // floating pin reads high through the pull-up
    assign hw_disable_w = tx_disable_pin_i | ~tx_disable_driven_i;

    tx_laser_guard i_tx_laser_guard (
        .clk_sys_i(clk_sys_i),
        .reset_n_i(reset_n_i),
        .hw_disable_i(hw_disable_w),
        .soft_disable_i(s_q.soft_disable),
        .fault_event_i(laser_fault_i | unsafe_power_i),
        .laser_on_o(laser_on_w),
        .fault_o(fault_w)
    );

    ////////////////////////////////////////////////////////////////////////////////

    assign scl_rise = scl_i & ~s_q.scl_q;
    assign scl_fall = ~scl_i & s_q.scl_q;
    assign start_cond = scl_i & s_q.scl_q & ~sda_i & s_q.sda_q;
    assign stop_cond = scl_i & s_q.scl_q & sda_i & ~s_q.sda_q;

    always_comb
    begin
        status_byte = 8'h00;
        status_byte[BIT_DISABLE_STATE] = s_q.hw_disable;
        status_byte[BIT_SOFT_DISABLE] = s_q.soft_disable;
        status_byte[BIT_TX_FAULT] = fault_w;
        status_byte[BIT_RX_SIGNAL_LOST] = s_q.rx_lost;
    end

    // live values big-endian, high byte at the even offset
    always_comb
    begin
        rd_byte = s_q.sel_diag ? diag_mem[s_q.ptr] : id_mem[s_q.ptr];
        if (s_q.sel_diag)
        begin
            case (s_q.ptr)
                OFS_TX_RX_CONTROL_STATUS: rd_byte = status_byte;
                OFS_TEMP: rd_byte = temp_i[15:8];
                OFS_TEMP + 8'h01: rd_byte = temp_i[7:0];
                OFS_VCC: rd_byte = vcc_i[15:8];
                OFS_VCC + 8'h01: rd_byte = vcc_i[7:0];
                OFS_TX_BIAS: rd_byte = tx_bias_i[15:8];
                OFS_TX_BIAS + 8'h01: rd_byte = tx_bias_i[7:0];
                OFS_TX_POWER: rd_byte = tx_power_i[15:8];
                OFS_TX_POWER + 8'h01: rd_byte = tx_power_i[7:0];
                OFS_RX_POWER: rd_byte = rx_power_i[15:8];
                OFS_RX_POWER + 8'h01: rd_byte = rx_power_i[7:0];
                default: rd_byte = diag_mem[s_q.ptr];
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////

    always_comb
    begin
        s_d = s_q;
        mem_we = 1'b0;
        s_d.scl_q = scl_i;
        s_d.sda_q = sda_i;
        s_d.hw_disable = hw_disable_w;
        s_d.rx_lost = rx_signal_lost_i;
        // open collector: pull low only while healthy
        s_d.fault_oe = ~fault_w;
        s_d.laser_en = laser_on_w;
        if (start_cond)
        begin
            s_d.st = TW_ADDR;
            s_d.bit_cnt = 4'h0;
            s_d.sda_oe = 1'b0;
        end
        else if (stop_cond)
        begin
            s_d.st = TW_IDLE;
            s_d.sda_oe = 1'b0;
        end
        else
        begin
            case (s_q.st)
                TW_IDLE:
                begin
                    s_d.sda_oe = 1'b0;
                end
                TW_ADDR, TW_WADDR, TW_WDATA:
                begin
                    if (scl_rise)
                    begin
                        s_d.shreg = {s_q.shreg[6:0], sda_i};
                        s_d.bit_cnt = s_q.bit_cnt + 4'h1;
                    end
                    else if (scl_fall && s_q.bit_cnt == BITS_PER_BYTE)
                    begin
                        s_d.bit_cnt = 4'h0;
                        s_d.sda_oe = 1'b1;
                        if (s_q.st == TW_ADDR)
                        begin
                            s_d.st = TW_ADDR_ACK;
                            s_d.rd_mode = s_q.shreg[0];
                            s_d.sel_diag = (s_q.shreg[7:1] == DEV_ADDR_DIAG[7:1]);
                            if (s_q.shreg[7:1] != DEV_ADDR_ID[7:1] && s_q.shreg[7:1] != DEV_ADDR_DIAG[7:1])
                            begin
                                s_d.st = TW_IDLE;
                                s_d.sda_oe = 1'b0;
                            end
                        end
                        else if (s_q.st == TW_WADDR)
                        begin
                            s_d.st = TW_WADDR_ACK;
                            s_d.ptr = s_q.shreg;
                        end
                        else
                        begin
                            s_d.st = TW_WDATA_ACK;
                            mem_we = 1'b1;
                            if (s_q.sel_diag && s_q.ptr == OFS_TX_RX_CONTROL_STATUS)
                            begin
                                s_d.soft_disable = s_q.shreg[BIT_SOFT_DISABLE];
                            end
                            s_d.ptr = s_q.ptr + 8'h01;
                        end
                    end
                end
                TW_ADDR_ACK, TW_WADDR_ACK, TW_WDATA_ACK:
                begin
                    if (scl_fall)
                    begin
                        s_d.sda_oe = 1'b0;
                        s_d.st = (s_q.st == TW_ADDR_ACK) ? TW_WADDR : TW_WDATA;
                        if (s_q.st == TW_ADDR_ACK && s_q.rd_mode)
                        begin
                            s_d.st = TW_RDATA;
                            s_d.shreg = {rd_byte[6:0], 1'b0};
                            s_d.sda_oe = ~rd_byte[7];
                            s_d.bit_cnt = 4'h1;
                            s_d.ptr = s_q.ptr + 8'h01;
                        end
                    end
                end
                TW_RDATA:
                begin
                    if (scl_fall)
                    begin
                        if (s_q.bit_cnt == BITS_PER_BYTE)
                        begin
                            s_d.st = TW_RDATA_ACK;
                            s_d.sda_oe = 1'b0;
                        end
                        else
                        begin
                            s_d.sda_oe = ~s_q.shreg[7];
                            s_d.shreg = {s_q.shreg[6:0], 1'b0};
                            s_d.bit_cnt = s_q.bit_cnt + 4'h1;
                        end
                    end
                end
                TW_RDATA_ACK:
                begin
                    if (scl_rise)
                    begin
                        s_d.rd_more = ~sda_i;
                    end
                    else if (scl_fall)
                    begin
                        // master nack ends the burst, sda left released
                        s_d.st = TW_IDLE;
                        if (s_q.rd_more)
                        begin
                            s_d.st = TW_RDATA;
                            s_d.shreg = {rd_byte[6:0], 1'b0};
                            s_d.sda_oe = ~rd_byte[7];
                            s_d.bit_cnt = 4'h1;
                            s_d.ptr = s_q.ptr + 8'h01;
                        end
                    end
                end
                default:
                begin
                    s_d.st = TW_IDLE;
                    s_d.sda_oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            s_q <= '{st: TW_IDLE, scl_q: 1'b1, sda_q: 1'b1, bit_cnt: 4'h0, shreg: 8'h00,
                     sel_diag: 1'b0, rd_mode: 1'b0, rd_more: 1'b0, ptr: RST_PTR, sda_oe: 1'b0,
                     soft_disable: RST_SOFT_DISABLE, hw_disable: RST_HW_DISABLE_SEEN, rx_lost: 1'b1,
                     fault_oe: 1'b0, laser_en: 1'b0};
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // plain storage, no reset: contents are whatever the host last wrote
    always_ff @(posedge clk_sys_i)
    begin
        if (mem_we)
        begin
            if (s_q.sel_diag)
            begin
                diag_mem[s_q.ptr] <= s_q.shreg;
            end
            else
            begin
                id_mem[s_q.ptr] <= s_q.shreg;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////

    assign sda_o = 1'b0;
    assign sda_oe_o = s_q.sda_oe;
    assign laser_enable_o = s_q.laser_en;
    assign tx_fault_o = 1'b0;
    assign tx_fault_oe_o = s_q.fault_oe;
    assign rx_signal_lost_pin_o = s_q.rx_lost;

endmodule

// [bench/transceiver_tx_control_diag_props.sv]
`timescale 1ns/10ps
module transceiver_tx_control_diag_props
    import transceiver_tx_control_diag_pkg::*;
(
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    // control and fault sources
    input wire logic tx_disable_pin_i,
    input wire logic tx_disable_driven_i,
    input wire logic laser_fault_i,
    input wire logic unsafe_power_i,
    input wire logic rx_signal_lost_i,
    // two-wire
    input wire logic scl_i,
    input wire logic sda_o,
    input wire logic sda_oe_o,
    // pins
    input wire logic laser_enable_o,
    input wire logic tx_fault_o,
    input wire logic tx_fault_oe_o,
    input wire logic rx_signal_lost_pin_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!reset_n_i);
    logic eff_dis;
    logic [2:0] up_q;
    logic [2:0] up_d;
    assign eff_dis = tx_disable_pin_i | ~tx_disable_driven_i;
    // settle counter, so reset values do not look like a latched fault
    always_comb up_d = (up_q == 3'h7) ? up_q : up_q + 3'h1;
    always_ff @(posedge clk_sys_i or negedge reset_n_i)
        if (!reset_n_i)
            up_q <= 3'h0;
        else
            up_q <= up_d;
    ////////////////////////////////////////////////////////////////
    sequence fault_seen;
        laser_fault_i || unsafe_power_i;
    endsequence
    sequence quiet_fault;
        ((up_q == 3'h7) && $stable(eff_dis)) ##1 $stable(eff_dis) ##1 ($stable(eff_dis) && !tx_fault_oe_o);
    endsequence
    chk_pin_laser_off: assert property (tx_disable_pin_i && tx_disable_driven_i |-> ##2 !laser_enable_o)
        else $error("laser on with disable pin high");
    chk_float_laser_off: assert property (!tx_disable_driven_i |-> ##2 !laser_enable_o)
        else $error("laser on with disable pin floating");
    chk_fault_sets_pins: assert property (fault_seen |-> ##2 (!tx_fault_oe_o && !laser_enable_o))
        else $error("fault did not raise fault line and stop laser");
    chk_fault_stays_latched: assert property (quiet_fault |=> !tx_fault_oe_o)
        else $error("fault cleared without disable toggle");
    chk_open_drain_const: assert property (!tx_fault_o && !sda_o)
        else $error("open drain output driven high");
    chk_los_high: assert property (rx_signal_lost_i ##1 rx_signal_lost_i |-> rx_signal_lost_pin_o)
        else $error("signal lost pin low while input unusable");
    // pin holds its reset level one cycle past release, so skip the attempt at release
    chk_los_low: assert property (disable iff (!reset_n_i || (up_q == 3'h0))
        !rx_signal_lost_i ##1 !rx_signal_lost_i |-> !rx_signal_lost_pin_o)
        else $error("signal lost pin high while input adequate");
    chk_laser_no_fault: assert property (laser_enable_o |-> tx_fault_oe_o)
        else $error("laser on while fault reported");
    chk_sda_on_fall: assert property ($changed(sda_oe_o) |-> !scl_i && !$past(scl_i))
        else $error("data line changed outside clock low phase");
endmodule
bind transceiver_tx_control_diag transceiver_tx_control_diag_props i_transceiver_tx_control_diag_props (
    .clk_sys_i, .reset_n_i, .tx_disable_pin_i, .tx_disable_driven_i, .laser_fault_i, .unsafe_power_i,
    .rx_signal_lost_i, .scl_i, .sda_o, .sda_oe_o, .laser_enable_o, .tx_fault_o, .tx_fault_oe_o,
    .rx_signal_lost_pin_o
);

// [bench/tw_host_model.sv]
`timescale 1ns/10ps
module tw_host_model
(
    // clock
    input wire logic clk_sys_i,
    // two-wire bus
    input wire logic sda_oe_i,
    output logic scl_o,
    output logic sda_o
);
    logic pull_q;
    // resolved line, pull-up wins when nobody pulls low
    assign sda_o = ~(pull_q | sda_oe_i);
    initial
    begin
        scl_o = 1'b1;
        pull_q = 1'b0;
    end
    task automatic ticks(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask
    // phases of at least 4 clk, double the minimum
    task automatic tw_bit(input logic b, output logic r);
        pull_q <= ~b;
        ticks(3);
        scl_o <= 1'b1;
        ticks(4);
        r = sda_o;
        scl_o <= 1'b0;
        ticks(2);
    endtask
    task automatic tw_start();
        pull_q <= 1'b0;
        ticks(2);
        scl_o <= 1'b1;
        ticks(3);
        pull_q <= 1'b1;
        ticks(3);
        scl_o <= 1'b0;
        ticks(2);
    endtask
    task automatic tw_stop();
        pull_q <= 1'b1;
        ticks(3);
        scl_o <= 1'b1;
        ticks(3);
        pull_q <= 1'b0;
        ticks(3);
    endtask
    task automatic tw_send(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            tw_bit(d[i], r);
        tw_bit(1'b1, r);
        ack = ~r;
    endtask
    task automatic tw_recv(input logic more, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            tw_bit(1'b1, r);
            d[i] = r;
        end
        tw_bit(~more, r);
    endtask
    task automatic wr_pair(input logic [7:0] dev, input logic [7:0] ofs, input logic [15:0] v, output logic ack);
        logic [3:0] a;
        tw_start();
        tw_send(dev, a[0]);
        tw_send(ofs, a[1]);
        tw_send(v[15:8], a[2]);
        tw_send(v[7:0], a[3]);
        tw_stop();
        ack = &a;
    endtask
    task automatic rd_pair(input logic [7:0] dev, input logic [7:0] ofs, output logic [15:0] v, output logic ack);
        logic [2:0] a;
        tw_start();
        tw_send(dev, a[0]);
        tw_send(ofs, a[1]);
        tw_start();
        tw_send(dev | 8'h01, a[2]);
        tw_recv(1'b1, v[15:8]);
        tw_recv(1'b0, v[7:0]);
        tw_stop();
        ack = &a;
    endtask
endmodule

// [bench/transceiver_tx_control_diag_tb.sv]
`timescale 1ns/10ps
module transceiver_tx_control_diag_tb
    import transceiver_tx_control_diag_pkg::*;
;
    logic clk_sys_i, reset_n_i, pin, driven, lf, up, rl;
    logic [15:0] mon [5];
    wire scl, sda_line, sda_o, sda_oe_o, laser_enable_o, tx_fault_o, tx_fault_oe_o, los_pin, fault_line;
    int bad_count, comparisons;
    // host pull-up on the fault line
    assign fault_line = tx_fault_oe_o ? tx_fault_o : 1'b1;
    transceiver_tx_control_diag i_transceiver_tx_control_diag (
        .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .tx_disable_pin_i(pin), .tx_disable_driven_i(driven),
        .laser_fault_i(lf), .unsafe_power_i(up), .rx_signal_lost_i(rl), .temp_i(mon[0]), .vcc_i(mon[1]),
        .tx_bias_i(mon[2]), .tx_power_i(mon[3]), .rx_power_i(mon[4]), .scl_i(scl), .sda_i(sda_line),
        .sda_o(sda_o), .sda_oe_o(sda_oe_o), .laser_enable_o(laser_enable_o), .tx_fault_o(tx_fault_o),
        .tx_fault_oe_o(tx_fault_oe_o), .rx_signal_lost_pin_o(los_pin)
    );
    tw_host_model i_tw_host_model (.clk_sys_i(clk_sys_i), .sda_oe_i(sda_oe_o), .scl_o(scl), .sda_o(sda_line));
    ////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        if (bad_count == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic check_bit(input logic got, input logic exp);
        check({15'h0, got}, {15'h0, exp});
    endtask
    task automatic ticks(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask
    task automatic wr(input logic [7:0] dev, input logic [7:0] ofs, input logic [15:0] v);
        logic ack;
        i_tw_host_model.wr_pair(dev, ofs, v, ack);
        check_bit(ack, 1'b1);
    endtask
    // full low compares only the first byte; the next one may be unwritten
    task automatic rd(input logic [7:0] dev, input logic [7:0] ofs, input logic [15:0] exp, input bit full);
        logic [15:0] v;
        logic ack;
        i_tw_host_model.rd_pair(dev, ofs, v, ack);
        check_bit(ack, 1'b1);
        check(full ? v : {v[15:8], 8'h00}, full ? exp : {exp[15:8], 8'h00});
    endtask
    ////////////////////////////////////////////////////////////////
    initial
    begin
        clk_sys_i = 1'b0;
        forever #4 clk_sys_i = ~clk_sys_i;
    end
    initial
    begin
        #(8 * 60000);
        bad_count++;
        wrap_up();
    end
    initial
    begin
        logic [15:0] v;
        logic ack;
        reset_n_i = 1'b0;
        pin = 1'b0;
        driven = 1'b0;
        lf = 1'b0;
        up = 1'b0;
        rl = 1'b0;
        for (int k = 0; k < 5; k++)
            mon[k] = {8'(k + 1), 8'(8'hc0 + k)};
        ticks(16);
        reset_n_i <= 1'b1;
        ticks(4);
        check_bit(laser_enable_o, 1'b0);
        driven <= 1'b1;
        ticks(4);
        check_bit(laser_enable_o, 1'b1);
        pin <= 1'b1;
        ticks(4);
        check_bit(laser_enable_o, 1'b0);
        pin <= 1'b0;
        wr(DEV_ADDR_DIAG, OFS_TX_RX_CONTROL_STATUS, 16'h4000);
        check_bit(laser_enable_o, 1'b0);
        rd(DEV_ADDR_DIAG, OFS_TX_RX_CONTROL_STATUS, 16'h4000, 1'b0);
        wr(DEV_ADDR_DIAG, OFS_TX_RX_CONTROL_STATUS, 16'h0000);
        check_bit(laser_enable_o, 1'b1);
        rl <= 1'b1;
        pin <= 1'b1;
        ticks(3);
        check_bit(los_pin, 1'b1);
        rd(DEV_ADDR_DIAG, OFS_TX_RX_CONTROL_STATUS, 16'h8200, 1'b0);
        rl <= 1'b0;
        pin <= 1'b0;
        ticks(3);
        check_bit(los_pin, 1'b0);
        rd(DEV_ADDR_DIAG, OFS_TX_RX_CONTROL_STATUS, 16'h0000, 1'b0);
        for (int k = 0; k < 5; k++)
            rd(DEV_ADDR_DIAG, OFS_TEMP + 8'(2 * k), mon[k], 1'b1);
        wr(DEV_ADDR_ID, 8'h10, 16'h1234);
        wr(DEV_ADDR_DIAG, 8'h10, 16'habcd);
        rd(DEV_ADDR_ID, 8'h10, 16'h1234, 1'b1);
        rd(DEV_ADDR_DIAG, 8'h10, 16'habcd, 1'b1);
        wr(DEV_ADDR_ID, 8'hff, 16'h5aa5);
        rd(DEV_ADDR_ID, 8'hff, 16'h5aa5, 1'b1);
        i_tw_host_model.rd_pair(8'ha4, 8'h10, v, ack);
        check_bit(ack, 1'b0);
        for (int s = 0; s < 2; s++)
        begin
            if (s == 0)
                lf <= 1'b1;
            else
                up <= 1'b1;
            ticks(1);
            lf <= 1'b0;
            up <= 1'b0;
            ticks(6);
            check_bit(fault_line, 1'b1);
            check_bit(laser_enable_o, 1'b0);
            rd(DEV_ADDR_DIAG, OFS_TX_RX_CONTROL_STATUS, 16'h0400, 1'b0);
            check_bit(fault_line, 1'b1);
            // toggle far shorter than the host spacing; the device does not time it
            pin <= 1'b1;
            ticks(4);
            pin <= 1'b0;
            ticks(6);
            check_bit(fault_line, 1'b0);
            check_bit(laser_enable_o, 1'b1);
        end
        wr(DEV_ADDR_DIAG, OFS_TX_RX_CONTROL_STATUS, 16'h4000);
        lf <= 1'b1;
        ticks(1);
        lf <= 1'b0;
        reset_n_i <= 1'b0;
        ticks(2);
        reset_n_i <= 1'b1;
        ticks(6);
        check_bit(fault_line, 1'b0);
        check_bit(laser_enable_o, 1'b1);
        rd(DEV_ADDR_DIAG, OFS_TX_RX_CONTROL_STATUS, 16'h0000, 1'b0);
        wrap_up();
    end
endmodule
